// >>> iod_defines.svh
`ifndef IOD_DEFINES_SVH
`define IOD_DEFINES_SVH
`define IOD_OP_NOP 8'h00
`define IOD_OP_IN_PT0 8'h08
`define IOD_OP_IN_PT1 8'h09
`define IOD_OP_IN_PT2 8'h0A
`define IOD_OP_RD_SR0 8'h0C
`define IOD_OP_RD_SR1 8'h0D
`define IOD_OP_OUT_PT0 8'h38
`define IOD_OP_OUT_PT1 8'h39
`define IOD_OP_OUT_PT2 8'h3A
`define IOD_OP_WR_SR0 8'h3C
`define IOD_OP_WR_SR1 8'h3D
`define IOD_OP_WR_SR2 8'h3E
`define IOD_OP_EN_SI 8'h85
`define IOD_OP_OR_PT0 8'h88
`define IOD_OP_OR_PT1 8'h89
`define IOD_OP_OR_PT2 8'h8A
`define IOD_OP_RD_PR 8'h8C
`define IOD_OP_WR_PR 8'h8D
`define IOD_OP_AND_PR 8'h8E
`define IOD_OP_OR_PR 8'h8F
`define IOD_OP_SERIAL_IRQ_DISABLE_OP 8'h95
`define IOD_OP_AND_PT0 8'h98
`define IOD_OP_AND_PT1 8'h99
`define IOD_OP_AND_PT2 8'h9A
`define IOD_OP_IMM_SR0 8'h9C
`define IOD_OP_IMM_SR1 8'h9D
`define IOD_OP_IMM_SR2 8'h9E
`define IOD_OP_JMP_TFLAG 8'h16
`define IOD_OP_JMP_NO_TFLAG 8'h06
`define IOD_PC_LOW_BITS 11
`define IOD_PT2_PINS 4
`endif

// >>> iod_pkg.sv
package iod_pkg;
   typedef enum logic [1:0]
   {
      IOD_IDLE = 2'b00,
      IOD_EXEC2 = 2'b01,
      IOD_RMW = 2'b10
   } iod_phase_t;

   typedef enum logic [3:0]
   {
      IOD_K_NONE = 4'h0,
      IOD_K_IN = 4'h1,
      IOD_K_OUT = 4'h2,
      IOD_K_PAND = 4'h3,
      IOD_K_POR = 4'h4,
      IOD_K_DRD = 4'h5,
      IOD_K_DWR = 4'h6,
      IOD_K_DAND = 4'h7,
      IOD_K_DOR = 4'h8,
      IOD_K_SRD = 4'h9,
      IOD_K_SWA = 4'hA,
      IOD_K_SWI = 4'hB
   } iod_kind_t;

   // Decoded instruction fields
   typedef struct packed
   {
      iod_kind_t kind;
      logic [1:0] sel;
      logic two_byte;
   } iod_dec_t;

   // Access request toward ports, peripherals, serial unit
   typedef struct packed
   {
      logic port_we;
      logic [1:0] port_sel;
      logic [7:0] port_data;
      logic dx_re;
      logic dx_we;
      logic [7:0] dx_addr;
      logic [7:0] dx_data;
      logic ser_we;
      logic [1:0] ser_sel;
      logic [7:0] ser_data;
   } iod_access_t;
endpackage : iod_pkg

// >>> iod_opcode_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "iod_defines.svh"
module iod_opcode_decode
   import iod_pkg::*;
(
   // Opcode in, decoded out
   input wire logic [7:0] opcode,
   output var iod_pkg::iod_dec_t dec
);
   import iod_pkg::*;

   // Pure table lookup; unknown codes fall to none
   always_comb
   begin
      dec = '{kind: IOD_K_NONE, sel: opcode[1:0], two_byte: 1'b0};
      case (opcode)
         `IOD_OP_IN_PT0, `IOD_OP_IN_PT1, `IOD_OP_IN_PT2: dec.kind = IOD_K_IN;
         `IOD_OP_OUT_PT0, `IOD_OP_OUT_PT1, `IOD_OP_OUT_PT2: dec.kind = IOD_K_OUT;
         `IOD_OP_AND_PT0, `IOD_OP_AND_PT1, `IOD_OP_AND_PT2:
         begin
            dec.kind = IOD_K_PAND;
            dec.two_byte = 1'b1;
         end
         `IOD_OP_OR_PT0, `IOD_OP_OR_PT1, `IOD_OP_OR_PT2:
         begin
            dec.kind = IOD_K_POR;
            dec.two_byte = 1'b1;
         end
         `IOD_OP_RD_PR:
         begin
            dec.kind = IOD_K_DRD;
            dec.two_byte = 1'b1;
         end
         `IOD_OP_WR_PR:
         begin
            dec.kind = IOD_K_DWR;
            dec.two_byte = 1'b1;
         end
         `IOD_OP_AND_PR:
         begin
            dec.kind = IOD_K_DAND;
            dec.two_byte = 1'b1;
         end
         `IOD_OP_OR_PR:
         begin
            dec.kind = IOD_K_DOR;
            dec.two_byte = 1'b1;
         end
         `IOD_OP_RD_SR0, `IOD_OP_RD_SR1: dec.kind = IOD_K_SRD;
         `IOD_OP_WR_SR0, `IOD_OP_WR_SR1, `IOD_OP_WR_SR2:
         begin
            dec.kind = IOD_K_SWA;
            dec.sel = opcode[1:0] - 2'd0;
         end
         `IOD_OP_IMM_SR0, `IOD_OP_IMM_SR1, `IOD_OP_IMM_SR2:
         begin
            dec.kind = IOD_K_SWI;
            dec.two_byte = 1'b1;
         end
         default: dec.kind = IOD_K_NONE;
      endcase
   end
endmodule : iod_opcode_decode
`default_nettype wire

// >>> iod_io_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "iod_defines.svh"
module iod_io_decoder
   import iod_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Fetch unit: byte presented with a strobe each cycle
   input wire logic fetch_valid,
   input wire logic [7:0] fetch_byte,
   input wire logic [15:0] pc_in,
   // Datapath
   input wire logic [7:0] acc_in,
   output logic acc_we,
   output logic [7:0] acc_data,
   output logic [15:0] pc_out,
   output logic pc_we,
   output logic busy,
   // Parallel port pins and latches
   input wire logic [7:0] first_parallel_port,
   input wire logic [7:0] second_parallel_port,
   input wire logic [3:0] third_parallel_port,
   output logic [7:0] port_latch0,
   output logic [7:0] port_latch1,
   output logic [7:0] port_latch2,
   // Peripheral register space
   input wire logic [7:0] dx_rdata,
   output var iod_pkg::iod_access_t acc_req,
   // Serial interface: status read returns status, not control
   input wire logic [7:0] serial_data_register,
   input wire logic [7:0] serial_status,
   output logic serial_irq_en,
   // Timer flag service
   output logic timer_flag_clr
);
   import iod_pkg::*;

   typedef struct packed
   {
      iod_phase_t phase;
      iod_dec_t dec;
      logic [7:0] addr;
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] p2;
      logic acc_we;
      logic [7:0] acc_data;
      logic pc_we;
      logic [15:0] pc;
      logic irq_en;
      logic tf_clr;
      iod_access_t req;
   } iod_state_t;

   iod_state_t st;
   iod_state_t next_st;
   iod_dec_t dec_now;
   logic [7:0] p0_s1, p0_s2, p0_s3;
   logic [7:0] p1_s1, p1_s2, p1_s3;
   logic [3:0] p2_s1, p2_s2, p2_s3;
   logic [7:0] p0_q, p1_q;
   logic [3:0] p2_q;

   iod_opcode_decode u_dec
   (
      .opcode(fetch_byte),
      .dec(dec_now)
   );

   // Pin synchronisers; value updates only once stages two and three agree
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         {p0_s1, p0_s2, p0_s3, p0_q} <= '0;
         {p1_s1, p1_s2, p1_s3, p1_q} <= '0;
         {p2_s1, p2_s2, p2_s3, p2_q} <= '0;
      end
      else
      begin
         p0_s1 <= first_parallel_port;
         p0_s2 <= p0_s1;
         p0_s3 <= p0_s2;
         p1_s1 <= second_parallel_port;
         p1_s2 <= p1_s1;
         p1_s3 <= p1_s2;
         p2_s1 <= third_parallel_port;
         p2_s2 <= p2_s1;
         p2_s3 <= p2_s2;
         if (p0_s2 == p0_s3)
            p0_q <= p0_s3;
         if (p1_s2 == p1_s3)
            p1_q <= p1_s3;
         if (p2_s2 == p2_s3)
            p2_q <= p2_s3;
      end
   end

   // Next-state logic: one opcode per idle cycle, second cycle does the access
   always_comb
   begin
      logic [7:0] operand;
      logic [7:0] latch;
      next_st = st;
      operand = fetch_byte;
      latch = st.p0;
      next_st.acc_we = 1'b0;
      next_st.pc_we = 1'b0;
      next_st.tf_clr = 1'b0;
      next_st.req.port_we = 1'b0;
      next_st.req.dx_re = 1'b0;
      next_st.req.dx_we = 1'b0;
      next_st.req.ser_we = 1'b0;
      case (st.dec.sel)
         2'd1: latch = st.p1;
         2'd2: latch = st.p2;
         default: latch = st.p0;
      endcase
      case (st.phase)
         IOD_IDLE:
         begin
            if (fetch_valid)
            begin
               next_st.dec = dec_now;
               if (fetch_byte == `IOD_OP_EN_SI)
                  next_st.irq_en = 1'b1;
               else if (fetch_byte == `IOD_OP_SERIAL_IRQ_DISABLE_OP)
                  next_st.irq_en = 1'b0;
               else if (fetch_byte == `IOD_OP_NOP)
               begin
                  next_st.pc_we = 1'b1;
                  next_st.pc = {pc_in[15:`IOD_PC_LOW_BITS],
                     pc_in[`IOD_PC_LOW_BITS-1:0] + 11'd1};
               end
               else if (fetch_byte == `IOD_OP_JMP_TFLAG || fetch_byte == `IOD_OP_JMP_NO_TFLAG)
                  next_st.tf_clr = 1'b1;
               else if (dec_now.kind != IOD_K_NONE)
                  next_st.phase = IOD_EXEC2;
            end
         end
         IOD_EXEC2:
         begin
            // Two-byte forms take the operand now, single-byte forms use A
            next_st.phase = IOD_IDLE;
            operand = st.dec.two_byte ? fetch_byte : acc_in;
            case (st.dec.kind)
               IOD_K_IN:
               begin
                  next_st.acc_we = 1'b1;
                  case (st.dec.sel)
                     2'd0: next_st.acc_data = p0_q;
                     2'd1: next_st.acc_data = p1_q;
                     default: next_st.acc_data = {4'h0, p2_q};
                  endcase
               end
               IOD_K_OUT, IOD_K_PAND, IOD_K_POR:
               begin
                  if (st.dec.kind == IOD_K_PAND)
                     latch = latch & operand;
                  else if (st.dec.kind == IOD_K_POR)
                     latch = latch | operand;
                  else
                     latch = acc_in;
                  next_st.req.port_we = 1'b1;
                  next_st.req.port_sel = st.dec.sel;
                  next_st.req.port_data = latch;
                  case (st.dec.sel)
                     2'd0: next_st.p0 = latch;
                     2'd1: next_st.p1 = latch;
                     default: next_st.p2 = latch;
                  endcase
               end
               IOD_K_DRD, IOD_K_DAND, IOD_K_DOR:
               begin
                  next_st.req.dx_re = 1'b1;
                  next_st.req.dx_addr = fetch_byte;
                  next_st.addr = fetch_byte;
                  if (st.dec.kind != IOD_K_DRD)
                     next_st.phase = IOD_RMW;
               end
               IOD_K_DWR:
               begin
                  next_st.req.dx_we = 1'b1;
                  next_st.req.dx_addr = fetch_byte;
                  next_st.req.dx_data = acc_in;
               end
               IOD_K_SRD:
               begin
                  next_st.acc_we = 1'b1;
                  next_st.acc_data = st.dec.sel[0] ? serial_status
                     : serial_data_register;
               end
               IOD_K_SWA, IOD_K_SWI:
               begin
                  next_st.req.ser_we = 1'b1;
                  next_st.req.ser_sel = st.dec.sel - (st.dec.kind == IOD_K_SWA ? 2'd0 : 2'd0);
                  next_st.req.ser_data = operand;
               end
               default: next_st.phase = IOD_IDLE;
            endcase
         end
         IOD_RMW:
         begin
            // Peripheral read data stands in the read strobe's own cycle
            next_st.phase = IOD_IDLE;
            next_st.req.dx_we = 1'b1;
            next_st.req.dx_addr = st.addr;
            next_st.req.dx_data = (st.dec.kind == IOD_K_DAND) ? (dx_rdata & acc_in)
               : (dx_rdata | acc_in);
         end
         default: next_st.phase = IOD_IDLE;
      endcase
      // Plain move: read result lands in A the cycle after the strobe
      if (st.req.dx_re && st.dec.kind == IOD_K_DRD)
      begin
         next_st.acc_we = 1'b1;
         next_st.acc_data = dx_rdata;
      end
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   always_comb
   begin
      acc_we = st.acc_we;
      acc_data = st.acc_data;
      pc_we = st.pc_we;
      pc_out = st.pc;
      busy = (st.phase != IOD_IDLE);
      port_latch0 = st.p0;
      port_latch1 = st.p1;
      port_latch2 = st.p2;
      acc_req = st.req;
      serial_irq_en = st.irq_en;
      timer_flag_clr = st.tf_clr;
   end

   a_in_third_zero: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_EXEC2 && st.dec.kind == IOD_K_IN && st.dec.sel == 2'd2)
      |=> acc_we && acc_data[7:4] == 4'h0)
      else $error("third port read upper nibble not zero");
   a_irq_enable_set: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_IDLE && fetch_valid && fetch_byte == `IOD_OP_EN_SI)
      |=> serial_irq_en)
      else $error("serial irq enable not set");
   a_irq_disable_clr: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_IDLE && fetch_valid && fetch_byte == `IOD_OP_SERIAL_IRQ_DISABLE_OP)
      |=> !serial_irq_en)
      else $error("serial irq enable not cleared");
   a_nop_bank_kept: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_IDLE && fetch_valid && fetch_byte == `IOD_OP_NOP)
      |=> pc_we && pc_out[15:11] == $past(pc_in[15:11]))
      else $error("nop changed bank bits");
   a_tf_clear: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_IDLE && fetch_valid && fetch_byte == `IOD_OP_JMP_TFLAG)
      |=> timer_flag_clr)
      else $error("timer flag not cleared");
   a_port_and: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_EXEC2 && st.dec.kind == IOD_K_PAND && st.dec.sel == 2'd0)
      |=> port_latch0 == ($past(port_latch0) & $past(fetch_byte)))
      else $error("port and result wrong");
   a_port_or: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_EXEC2 && st.dec.kind == IOD_K_POR && st.dec.sel == 2'd1)
      |=> port_latch1 == ($past(port_latch1) | $past(fetch_byte)))
      else $error("port or result wrong");
   a_port_write: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_EXEC2 && st.dec.kind == IOD_K_OUT && st.dec.sel == 2'd0)
      |=> port_latch0 == $past(acc_in))
      else $error("port write wrong");
   a_dx_write: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_EXEC2 && st.dec.kind == IOD_K_DWR)
      |=> acc_req.dx_we && acc_req.dx_addr == $past(fetch_byte))
      else $error("peripheral write wrong");
   a_dx_rmw: assert property (@(posedge ref_clk) disable iff (reset)
      (st.phase == IOD_EXEC2 && st.dec.kind == IOD_K_DAND)
      |=> ##1 acc_req.dx_we && acc_req.dx_addr == $past(acc_req.dx_addr))
      else $error("peripheral rmw write missing");
endmodule : iod_io_decoder
`default_nettype wire

// >>> iod_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Accumulator and peripheral register space as the decoder sees them
module iod_core_model
   import iod_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Requests from the decoder
   input wire logic acc_we,
   input wire logic [7:0] acc_data,
   input wire iod_pkg::iod_access_t acc_req,
   // Answers back
   output logic [7:0] acc_in,
   output logic [7:0] dx_rdata
);
   logic [7:0] acc = 8'h00;
   logic [7:0] mem [256];
   logic [7:0] rd = 8'h00;
   assign acc_in = acc;
   // Read data stands in the strobe's own cycle; junk otherwise, never stale
   assign dx_rdata = acc_req.dx_re ? mem[acc_req.dx_addr] : rd;
   // Plain always so the bench may preload state between instructions
   always @(posedge ref_clk)
   begin
      if (acc_we)
         acc <= acc_data;
   end
   // Junk pattern flips every cycle so a late sample shows up
   always @(posedge ref_clk)
   begin
      rd <= ~rd;
      if (acc_req.dx_we)
         mem[acc_req.dx_addr] <= acc_req.dx_data;
   end
endmodule : iod_core_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import iod_pkg::*;
   logic ref_clk, reset, fetch_valid, acc_we, pc_we, busy, serial_irq_en, timer_flag_clr;
   logic [7:0] fetch_byte, pin0, pin1, ser_dat, ser_st, acc_data, acc_in, dx_rdata;
   logic [7:0] lat0, lat1, lat2, wdat_q;
   logic [3:0] pin2;
   logic [1:0] wsel_q;
   logic [15:0] pc_in, pc_out, pc_q;
   iod_access_t acc_req;
   int err_total = 0;
   int tests_run = 0;
   int clr_n = 0;
   logic [31:0] seed = 32'h0000_0048;

   iod_io_decoder dut (.ref_clk(ref_clk), .reset(reset), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte), .pc_in(pc_in), .acc_in(acc_in), .acc_we(acc_we),
      .acc_data(acc_data), .pc_out(pc_out), .pc_we(pc_we), .busy(busy),
      .first_parallel_port(pin0), .second_parallel_port(pin1), .third_parallel_port(pin2),
      .port_latch0(lat0), .port_latch1(lat1), .port_latch2(lat2), .dx_rdata(dx_rdata),
      .acc_req(acc_req), .serial_data_register(ser_dat), .serial_status(ser_st),
      .serial_irq_en(serial_irq_en), .timer_flag_clr(timer_flag_clr));
   iod_core_model pm (.ref_clk(ref_clk), .acc_we(acc_we), .acc_data(acc_data),
      .acc_req(acc_req), .acc_in(acc_in), .dx_rdata(dx_rdata));

   // Core clock, 100 ns period
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Capture one-cycle strobes so checks can look later
   always @(posedge ref_clk)
   begin
      if (acc_req.ser_we)
      begin
         wsel_q <= acc_req.ser_sel;
         wdat_q <= acc_req.ser_data;
      end
      if (pc_we)
         pc_q <= pc_out;
      if (timer_flag_clr)
         clr_n <= clr_n + 1;
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   function automatic logic [7:0] latch(input logic [7:0] p);
      return (p == 0) ? lat0 : (p == 1) ? lat1 : lat2;
   endfunction : latch

   // Third port has only four pins; upper bits read as zero
   function automatic logic [7:0] port_in(input logic [7:0] p);
      return (p == 0) ? pin0 : (p == 1) ? pin1 : {4'h0, pin2};
   endfunction : port_in

   function automatic logic [15:0] nop_pc(input logic [15:0] pc);
      return {pc[15:11], pc[10:0] + 11'h001};
   endfunction : nop_pc

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_cnt(input int got, input int exp);
      tests_run++;
      if (got != exp)
      begin
         err_total++;
         $display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   // Opcode, then operand with fetch still offered so a busy decoder must ignore it
   task automatic run_op(input logic [7:0] op, input logic [7:0] opd, input int nb);
      int n;
      n = 0;
      fetch_byte = op;
      fetch_valid = 1'b1;
      @(negedge ref_clk);
      fetch_byte = opd;
      fetch_valid = (nb != 0);
      while (busy === 1'b1 && n < 8)
      begin
         n++;
         @(negedge ref_clk);
      end
      if (n != 0)
         fetch_valid = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk_cnt(n, nb);
   endtask : run_op

   // Main sequence
   initial
   begin
      logic [7:0] p, a, b, v, addr;
      int i, n0;
      fetch_valid = 1'b0;
      fetch_byte = 8'h00;
      pc_in = 16'h0000;
      {pin0, pin1, pin2, ser_dat, ser_st} = '0;
      reset = 1'b1;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk_val({lat0, lat1}, 16'h0000);
      // Port reads, writes, AND and OR per port
      for (p = 0; p < 3; p++)
      begin
         pin0 = rnd();
         pin1 = rnd();
         v = rnd();
         pin2 = v[3:0];
         repeat (5) @(negedge ref_clk); // Pins pass a synchroniser first
         run_op(8'h08 + p, rnd(), 1);
         chk_val(pm.acc, port_in(p));
         v = rnd();
         pm.acc = v;
         run_op(8'h38 + p, rnd(), 1);
         chk_val(latch(p), v);
         a = rnd();
         b = latch(p) & a;
         run_op(8'h98 + p, a, 1);
         chk_val(latch(p), b);
         a = rnd();
         b = latch(p) | a;
         run_op(8'h88 + p, a, 1);
         chk_val(latch(p), b);
      end
      // Peripheral registers at both address ends and one random
      for (i = 0; i < 3; i++)
      begin
         addr = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
         v = rnd();
         pm.acc = v;
         run_op(8'h8D, addr, 1);
         chk_val(pm.mem[addr], v);
         a = rnd();
         pm.mem[addr] = a;
         v = rnd();
         pm.acc = v;
         run_op(8'h8E, addr, 2);
         chk_val(pm.mem[addr], a & v);
         a = pm.mem[addr];
         v = rnd();
         pm.acc = v;
         run_op(8'h8F, addr, 2);
         chk_val(pm.mem[addr], a | v);
         a = rnd();
         pm.mem[addr] = a;
         run_op(8'h8C, addr, 1);
         chk_val(pm.acc, a);
      end
      // Serial registers from accumulator and from immediate
      for (p = 0; p < 3; p++)
      begin
         v = rnd();
         pm.acc = v;
         run_op(8'h3C + p, rnd(), 1);
         chk_val({wsel_q, wdat_q}, {p[1:0], v});
         v = rnd();
         run_op(8'h9C + p, v, 1);
         chk_val({wsel_q, wdat_q}, {p[1:0], v});
      end
      // Serial reads; control write must not echo back on status read
      v = rnd();
      ser_dat = v;
      run_op(8'h0C, 8'h00, 1);
      chk_val(pm.acc, v);
      v = rnd();
      pm.acc = v;
      run_op(8'h3D, 8'h00, 1);
      b = ~v;
      ser_st = b;
      run_op(8'h0D, 8'h00, 1);
      chk_val(pm.acc, b);
      run_op(8'h85, 8'h00, 0);
      chk_val(serial_irq_en, 16'h0001);
      run_op(8'h95, 8'h00, 0);
      chk_val(serial_irq_en, 16'h0000);
      // Low field carry must not reach the bank bits
      pc_in = 16'hf7ff;
      run_op(8'h00, 8'h00, 0);
      chk_val(pc_q, nop_pc(pc_in));
      pc_in = {rnd(), rnd()};
      run_op(8'h00, 8'h00, 0);
      chk_val(pc_q, nop_pc(pc_in));
      n0 = clr_n;
      run_op(8'h16, 8'h00, 0);
      run_op(8'h06, 8'h00, 0);
      chk_cnt(clr_n, n0 + 2);
      // Opcode outside the group changes nothing
      v = pm.acc;
      a = lat0;
      run_op(8'h42, 8'h00, 0);
      chk_val({pm.acc, lat0}, {v, a});
      test_done();
   end

   // About 220 cycles expected; generous margin before declaring a hang
   initial
   begin
      #(5000 * 100);
      err_total++;
      test_done();
   end
endmodule : tb
`default_nettype wire
